// *** rtl/bmfs_regs.vh ***
// register map and timing constants of the buck mode and fault sequencer
`ifndef BMFS_REGS_VH
`define BMFS_REGS_VH
`define BMFS_CLK_HZ 20000000
`define BMFS_ADR_CTRL 8'h00
`define BMFS_ADR_STAT 8'h04
`define BMFS_ADR_IRQ_STAT 8'h08
`define BMFS_ADR_IRQ_MASK 8'h0C
`define BMFS_ADR_LIM_CNT 8'h10
`define BMFS_ADR_SS_LEVEL 8'h14
`define BMFS_ADR_PULSE_ON 8'h18
`define BMFS_CTRL_RST 8'h00
`define BMFS_MASK_RST 8'h00
`define BMFS_PULSE_ON_RST 8'h09
`define BMFS_LIM_EVENTS 6'd32
`define BMFS_RETRY_NS 66000
`define BMFS_RETRY_CYC ((`BMFS_RETRY_NS * 20) / 1000)
`define BMFS_SS_NS 800000
`define BMFS_SS_CYC ((`BMFS_SS_NS * 20) / 1000)
`define BMFS_PWM_KHZ 2400
`define BMFS_PWM_CYC ((`BMFS_CLK_HZ / 1000) / `BMFS_PWM_KHZ)
`define BMFS_PULSE_NS 420
`define BMFS_PULSE_CYC ((`BMFS_PULSE_NS * 20 + 999) / 1000)
`define BMFS_LOCKOUT_HYST_MV 200
`define BMFS_OT_HYST_C 20
`define BMFS_DISCHARGE_OHM 260
`define BMFS_EN_PULLDOWN_KOHM 400
`define BMFS_IRQ_LIM 0
`define BMFS_IRQ_RETRY 1
`define BMFS_IRQ_LOCKOUT 2
`define BMFS_IRQ_OT 3
`define BMFS_IRQ_GOOD 4
`define BMFS_IRQ_BAD 5
`endif

// *** rtl/bmfs_sequencer.v ***
// supervisory mode and fault sequencer for a synchronous step-down converter
// Summary of operation
// - at the current threshold, high side off, low side on at once
// - after 32 current-limit events stop switching, discharge, enter retry
// - wait 66 us in retry, then start again; repeat while overloaded
// - each start ramps the reference monotonically over 0.8 ms
// - a precharged output starts the ramp from its present level
// - medium and heavy load switch in PWM at 2.5 MHz (8 clocks)
// - discontinuous current enters light-load pulse mode seamlessly
// - light-load on-time is fixed by register, 9 clocks (450 ns) from reset
// - in the pulse-mode idle gap, hold supply-good and ignore lockout
// - near dropout keep high side on and low side off
// - shut down while lockout is asserted; hysteresis 200 mV analog
// - overtemperature stops switching; resumes once 20 C cooler
// - turn-on input high runs once CTRL bit 0 (sw_enable) is set; low forces full shutdown
// - 260 ohm discharge in shutdown, overtemp, lockout and retry
// - 400 kohm pulldown on turn-on input only while it is low
// - supply-good released above 95%, pulled low below 90%
// - supply-good low in shutdown, overtemp, lockout; off at no supply
// - supply-good is open drain, pull-down only
`timescale 1ns/1ps
`include "bmfs_regs.vh"
module bmfs_sequencer (
  input wire mclk,
  input wire rst,
  input wire [31:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  input wire [3:0] wb_sel_i,
  input wire wb_we_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  output reg wb_ack_o,
  output wire irq,
  input wire turn_on_pin,
  input wire switch_current_threshold,
  input wire low_input_lockout,
  input wire overtemp_threshold,
  input wire out_above_good,
  input wire out_below_bad,
  input wire current_discontinuous,
  input wire near_dropout,
  input wire supply_present,
  input wire [7:0] precharge_level,
  output reg hs_gate,
  output reg ls_gate,
  output reg [7:0] ref_level,
  output wire discharge_on,
  output wire en_pulldown_on,
  output wire supply_ok_output_out,
  output wire supply_ok_output_oe,
  output wire pulse_frequency_mode
);

  localparam ST_OFF = 3'd0;
  localparam ST_SOFT = 3'd1;
  localparam ST_RUN = 3'd2;
  localparam ST_RETRY = 3'd3;
  localparam ST_LOCK = 3'd4;
  localparam ST_HOT = 3'd5;

  localparam [31:0] SS_STEP = `BMFS_SS_CYC / 256;
  localparam [31:0] SS_LAST = SS_STEP - 1;
  localparam [31:0] RETRY_LAST = `BMFS_RETRY_CYC - 1;
  localparam [31:0] PWM_LAST = `BMFS_PWM_CYC - 1;
  // half the period high: nominal duty, the analog loop trims it
  localparam [31:0] PWM_ON = `BMFS_PWM_CYC / 2;
  localparam [15:0] SS_LAST_W = SS_LAST[15:0];
  localparam [15:0] RETRY_LAST_W = RETRY_LAST[15:0];
  localparam [3:0] PWM_LAST_W = PWM_LAST[3:0];
  localparam [7:0] PWM_ON_W = PWM_ON[7:0];

  // true in the first cycle that a state is held
  function entered;
    input [2:0] now_state;
    input [2:0] prev_state;
    input [2:0] target;
    begin
      entered = (now_state == target) && (prev_state != target);
    end
  endfunction

  // the limit edge that completes the event count
  function limit_full;
    input edge_seen;
    input [5:0] count;
    begin
      limit_full = edge_seen && (count == `BMFS_LIM_EVENTS - 6'd1);
    end
  endfunction

  function at_nominal;
    input [7:0] level;
    begin
      at_nominal = (level == 8'hFF);
    end
  endfunction

  // every analog or pin input passes two flops
  reg [9:0] s1_reg;
  reg [9:0] s2_reg;
  reg [7:0] pre1_reg;
  reg [7:0] pre2_reg;
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      s1_reg <= 10'h000;
      s2_reg <= 10'h000;
    end else begin
      s1_reg <= {supply_present, near_dropout, current_discontinuous,
                 out_below_bad, out_above_good, overtemp_threshold,
                 low_input_lockout, switch_current_threshold,
                 turn_on_pin, 1'b0};
      s2_reg <= s1_reg;
    end
  end

  // a moving level may tear by a step; it is only taken at start-up
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      pre1_reg <= 8'h00;
      pre2_reg <= 8'h00;
    end else begin
      pre1_reg <= precharge_level;
      pre2_reg <= pre1_reg;
    end
  end
  wire en_s = s2_reg[1];
  wire ilim_s = s2_reg[2];
  wire lock_s = s2_reg[3];
  wire hot_s = s2_reg[4];
  wire good_s = s2_reg[5];
  wire bad_s = s2_reg[6];
  wire dcm_s = s2_reg[7];
  wire drop_s = s2_reg[8];
  wire vin_s = s2_reg[9];

  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [5:0] lim_cnt_reg;
  reg ilim_d_reg;
  reg [15:0] tmr_reg;
  reg [7:0] ctrl_reg;
  reg [7:0] mask_reg;
  reg [7:0] istat_reg;
  reg [7:0] pulse_on_reg;
  reg good_reg;
  reg [3:0] pwm_cnt_reg;
  reg [7:0] on_cnt_reg;
  reg in_pulse_reg;
  reg [2:0] state_d_reg;

  wire sw_enable = ctrl_reg[0];
  wire force_pwm = ctrl_reg[1];
  wire ilim_rise = ilim_s & ~ilim_d_reg;
  wire running = (state_reg == ST_SOFT) || (state_reg == ST_RUN);
  wire light_mode = running & dcm_s & ~force_pwm & ~drop_s;
  // idle gap of pulse mode: between on-times, no switch on
  wire pulse_gap = light_mode & ~in_pulse_reg;
  wire lock_seen = lock_s & ~pulse_gap;
  wire on_req = en_s & sw_enable;

  always @* begin
    state_next = state_reg;
    if (!on_req) begin
      state_next = ST_OFF;
    end else if (lock_seen) begin
      state_next = ST_LOCK;
    end else if (hot_s) begin
      state_next = ST_HOT;
    end else begin
      case (state_reg)
        ST_OFF: begin
          state_next = ST_SOFT;
        end
        ST_LOCK: begin
          state_next = ST_SOFT;
        end
        ST_HOT: begin
          state_next = ST_SOFT;
        end
        ST_SOFT: begin
          if (limit_full(ilim_rise, lim_cnt_reg)) begin
            state_next = ST_RETRY;
          end else if (at_nominal(ref_level)) begin
            state_next = ST_RUN;
          end
        end
        ST_RUN: begin
          if (limit_full(ilim_rise, lim_cnt_reg)) begin
            state_next = ST_RETRY;
          end
        end
        ST_RETRY: begin
          if (tmr_reg == RETRY_LAST_W) begin
            state_next = ST_SOFT;
          end
        end
        default: state_next = ST_OFF;
      endcase
    end
  end

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_OFF;
      state_d_reg <= ST_OFF;
      lim_cnt_reg <= 6'd0;
      ilim_d_reg <= 1'b0;
      tmr_reg <= 16'h0000;
      ref_level <= 8'h00;
    end else begin
      state_reg <= state_next;
      state_d_reg <= state_reg;
      ilim_d_reg <= ilim_s;
      if (state_next != state_reg) begin
        tmr_reg <= 16'h0000;
      end else if (state_reg == ST_SOFT && tmr_reg == SS_LAST_W) begin
        tmr_reg <= 16'h0000;
      end else begin
        tmr_reg <= tmr_reg + 16'h0001;
      end
      if (!running || state_next == ST_RETRY) begin
        lim_cnt_reg <= 6'd0;
      end else if (ilim_rise) begin
        lim_cnt_reg <= lim_cnt_reg + 6'd1;
      end
      // a precharged output is picked up where it stands
      if (state_next == ST_SOFT && state_reg != ST_SOFT) begin
        ref_level <= pre2_reg;
      end else if (!running) begin
        ref_level <= 8'h00;
      end else if (state_reg == ST_SOFT && tmr_reg == SS_LAST_W &&
                   !at_nominal(ref_level)) begin
        ref_level <= ref_level + 8'h01;
      end
    end
  end

  // switch drive: pwm period, fixed on-time pulses, dropout, limit
  wire [7:0] pwm_on = PWM_ON_W;
  wire pwm_high = ({4'h0, pwm_cnt_reg} < pwm_on);
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      pwm_cnt_reg <= 4'h0;
      on_cnt_reg <= 8'h00;
      in_pulse_reg <= 1'b0;
      hs_gate <= 1'b0;
      ls_gate <= 1'b0;
    end else begin
      if (pwm_cnt_reg == PWM_LAST_W) begin
        pwm_cnt_reg <= 4'h0;
      end else begin
        pwm_cnt_reg <= pwm_cnt_reg + 4'h1;
      end
      if (light_mode && !in_pulse_reg && !good_s) begin
        in_pulse_reg <= 1'b1;
        on_cnt_reg <= pulse_on_reg;
      end else if (in_pulse_reg) begin
        if (on_cnt_reg <= 8'h01 || !light_mode) begin
          in_pulse_reg <= 1'b0;
        end
        on_cnt_reg <= on_cnt_reg - 8'h01;
      end
      if (!running) begin
        hs_gate <= 1'b0;
        ls_gate <= 1'b0;
      end else if (ilim_s) begin
        hs_gate <= 1'b0;
        ls_gate <= 1'b1;
      end else if (drop_s) begin
        hs_gate <= 1'b1;
        ls_gate <= 1'b0;
      end else if (light_mode) begin
        hs_gate <= in_pulse_reg;
        ls_gate <= 1'b0;
      end else begin
        hs_gate <= pwm_high;
        ls_gate <= ~pwm_high;
      end
    end
  end

  // supply-good: hysteresis held in a flag, frozen during pulse gap
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      good_reg <= 1'b0;
    end else if (!running) begin
      good_reg <= 1'b0;
    end else if (!pulse_gap) begin
      if (good_s) begin
        good_reg <= 1'b1;
      end else if (bad_s) begin
        good_reg <= 1'b0;
      end
    end
  end
  // no supply leaves the pin released
  assign supply_ok_output_out = 1'b0;
  assign supply_ok_output_oe = vin_s & ~good_reg;

  assign discharge_on = (state_reg == ST_OFF) || (state_reg == ST_LOCK) ||
                        (state_reg == ST_HOT) ||
                        (state_reg == ST_RETRY);
  // pulldown follows the synchronized pin level, not software enable
  assign en_pulldown_on = ~en_s;
  assign pulse_frequency_mode = light_mode;

  // interrupt events
  wire [7:0] ev;
  assign ev[`BMFS_IRQ_LIM] = ilim_rise;
  assign ev[`BMFS_IRQ_RETRY] = entered(state_reg, state_d_reg,
                                       ST_RETRY);
  assign ev[`BMFS_IRQ_LOCKOUT] = entered(state_reg, state_d_reg,
                                         ST_LOCK);
  assign ev[`BMFS_IRQ_OT] = entered(state_reg, state_d_reg,
                                    ST_HOT);
  assign ev[`BMFS_IRQ_GOOD] = good_s & ~bad_s & running & ~good_reg;
  // loss of supply-good, only where the flag may move
  assign ev[`BMFS_IRQ_BAD] = bad_s & ~good_s & running & good_reg &
                             ~pulse_gap;
  assign ev[7:6] = 2'b00;
  assign irq = |(istat_reg & mask_reg);

  wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire [7:0] adr = wb_adr_i[7:0];
  wire rd_istat = req & ~wb_we_i & (adr == `BMFS_ADR_IRQ_STAT);

  // set wins over the clear-on-read, so no event is lost to a read
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      istat_reg <= 8'h00;
    end else begin
      istat_reg <= (rd_istat ? 8'h00 : istat_reg) | ev;
    end
  end

  // every access is answered one cycle after it is taken
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      ctrl_reg <= `BMFS_CTRL_RST;
      mask_reg <= `BMFS_MASK_RST;
      pulse_on_reg <= `BMFS_PULSE_ON_RST;
    end else begin
      wb_ack_o <= req;
      if (req && wb_we_i && wb_sel_i[0]) begin
        case (adr)
          `BMFS_ADR_CTRL: begin
            ctrl_reg <= wb_dat_i[7:0];
          end
          `BMFS_ADR_IRQ_MASK: begin
            mask_reg <= wb_dat_i[7:0];
          end
          `BMFS_ADR_PULSE_ON: begin
            pulse_on_reg <= wb_dat_i[7:0];
          end
          default: ;
        endcase
      end
      if (req && !wb_we_i) begin
        case (adr)
          `BMFS_ADR_CTRL: wb_dat_o <= {24'h0, ctrl_reg};
          `BMFS_ADR_STAT: wb_dat_o <= {22'h0, vin_s, good_reg,
                                       light_mode, drop_s, 1'b0,
                                       state_reg, hs_gate, ls_gate};
          `BMFS_ADR_IRQ_STAT: wb_dat_o <= {24'h0, istat_reg};
          `BMFS_ADR_IRQ_MASK: wb_dat_o <= {24'h0, mask_reg};
          `BMFS_ADR_LIM_CNT: wb_dat_o <= {26'h0, lim_cnt_reg};
          `BMFS_ADR_SS_LEVEL: wb_dat_o <= {24'h0, ref_level};
          `BMFS_ADR_PULSE_ON: wb_dat_o <= {24'h0, pulse_on_reg};
          default: wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end

endmodule

// *** tb/bmfs_monitor.sv ***
// concurrent checks on the sequencer ports
`timescale 1ns/1ps
module bmfs_monitor (
  input wire mclk,
  input wire rst,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  input wire turn_on_pin,
  input wire switch_current_threshold,
  input wire low_input_lockout,
  input wire overtemp_threshold,
  input wire current_discontinuous,
  input wire supply_present,
  input wire hs_gate,
  input wire ls_gate,
  input wire discharge_on,
  input wire en_pulldown_on,
  input wire supply_ok_output_out,
  input wire supply_ok_output_oe
);
  default clocking dc @(posedge mclk); endclocking
  default disable iff (rst);
  ack_next_a: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held");
  limit_cut_a: assert property (
    switch_current_threshold[*4] |-> !hs_gate) else $error("hs on at limit");
  pin_release_a: assert property (
    turn_on_pin[*4] |-> !en_pulldown_on) else $error("pulldown kept");
  pin_off_a: assert property (
    (!turn_on_pin)[*8] |-> en_pulldown_on && discharge_on && !hs_gate
    && !ls_gate && supply_ok_output_oe) else $error("not shut down");
  lockout_off_a: assert property (
    (low_input_lockout && supply_present && !current_discontinuous)[*8]
    |-> discharge_on && !hs_gate && !ls_gate && supply_ok_output_oe)
    else $error("lockout ignored");
  hot_off_a: assert property (
    (overtemp_threshold && supply_present)[*8] |-> discharge_on
    && !hs_gate && !ls_gate && supply_ok_output_oe)
    else $error("overtemp ignored");
  no_supply_a: assert property (
    (!supply_present)[*6] |-> !supply_ok_output_oe)
    else $error("good pin pulled unpowered");
  pull_only_a: assert property (
    supply_ok_output_out == 1'h0) else $error("good pin driven high");
  cover property ($rose(discharge_on) && turn_on_pin);
  cover property ($fell(supply_ok_output_oe));
  cover property (current_discontinuous && low_input_lockout);
endmodule

bind bmfs_sequencer bmfs_monitor i_bmfs_monitor (.*);

// *** tb/bmfs_power_stage.sv ***
// comparator and power stage stand-in facing the sequencer
`timescale 1ns/1ps
module bmfs_power_stage (
  input wire mclk,
  input wire overload,
  input wire droop,
  input wire hs_gate,
  input wire [7:0] ref_level,
  output reg switch_current_threshold = 1'h0,
  output reg out_above_good = 1'h0,
  output reg out_below_bad = 1'h1
);
  // output follows the reference; a short trips the limit each on-phase
  always @(posedge mclk) begin
    switch_current_threshold <= overload && hs_gate;
    out_above_good <= !droop && ref_level >= 8'hF3;
    out_below_bad <= droop || ref_level < 8'hE6;
  end
endmodule

// *** tb/tb_top.sv ***
// self-checking bench for the buck mode and fault sequencer
`timescale 1ns/1ps
`include "bmfs_regs.vh"
module tb_top;
  reg mclk = 1'h0;
  reg rst = 1'h1;
  reg [31:0] wb_adr_i = 32'h0;
  reg [31:0] wb_dat_i = 32'h0;
  reg [3:0] wb_sel_i = 4'hF;
  reg wb_we_i = 1'h0, wb_cyc_i = 1'h0, wb_stb_i = 1'h0;
  reg turn_on_pin = 1'h0, low_input_lockout = 1'h0;
  reg overtemp_threshold = 1'h0, current_discontinuous = 1'h0;
  reg near_dropout = 1'h0, supply_present = 1'h1;
  reg overload = 1'h0, droop = 1'h0;
  reg [7:0] precharge_level = 8'h00;
  wire [31:0] wb_dat_o;
  wire [7:0] ref_level;
  wire wb_ack_o, irq, switch_current_threshold, out_above_good;
  wire out_below_bad, hs_gate, ls_gate, discharge_on, en_pulldown_on;
  wire supply_ok_output_out, supply_ok_output_oe, pulse_frequency_mode;
  wire [6:0] st = {hs_gate, ls_gate, discharge_on, en_pulldown_on,
    supply_ok_output_oe, pulse_frequency_mode, irq};
  integer num_errors = 0, total_checks = 0, n;
  reg [31:0] q;
  time t0;
  bmfs_sequencer i_bmfs_sequencer (.*);
  bmfs_power_stage i_bmfs_power_stage (.*);
  initial forever #25 mclk = ~mclk;
  task chk(input [31:0] got, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("wrong value at %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task xfer(input [7:0] a, input [31:0] d, input w);
    begin
      @(posedge mclk);
      wb_adr_i <= {24'h0, a};
      wb_dat_i <= d;
      wb_we_i <= w;
      wb_cyc_i <= 1'h1;
      wb_stb_i <= 1'h1;
      n = 0;
      @(posedge mclk);
      while (wb_ack_o !== 1'h1 && n < 20) begin
        n = n + 1;
        @(posedge mclk);
      end
      q = wb_dat_o;
      wb_cyc_i <= 1'h0;
      wb_stb_i <= 1'h0;
      chk({31'h0, n < 20}, 32'h1);
    end
  endtask
  // flags settle through two sync stages, so give them eight cycles
  task look(input [6:0] m, input [6:0] e);
    begin
      repeat (8) @(posedge mclk);
      chk({25'h0, st & m}, {25'h0, e});
    end
  endtask
  task wref(input [7:0] v, input integer lim);
    begin
      n = 0;
      while (ref_level !== v && n < lim) begin
        @(posedge mclk);
        n = n + 1;
      end
      chk({24'h0, ref_level}, {24'h0, v});
    end
  endtask
  task wdis(input v);
    begin
      n = 0;
      while (discharge_on !== v && n < 2000) begin
        @(posedge mclk);
        n = n + 1;
      end
      chk({31'h0, discharge_on}, {31'h0, v});
    end
  endtask
  task ramp;
    begin
      wref(8'hFE, 1400);
      wref(8'hFF, 3300);
      look(7'h1C, 7'h00);
    end
  endtask
  task report_and_stop;
    begin
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  initial begin
    #3000000;
    num_errors = num_errors + 1;
    report_and_stop;
  end
  initial begin
    repeat (10) @(posedge mclk);
    rst <= 1'h0;
    look(7'h7E, 7'h1C);
    xfer(`BMFS_ADR_PULSE_ON, 32'h0, 1'h0);
    chk(q, `BMFS_PULSE_CYC);
    xfer(8'h20, 32'hFF, 1'h1);
    xfer(8'h20, 32'h0, 1'h0);
    chk(q, 32'h0);
    $display("test reset done");
    precharge_level <= 8'hFE;
    xfer(`BMFS_ADR_CTRL, 32'h1, 1'h1);
    turn_on_pin <= 1'h1;
    ramp;
    @(posedge hs_gate);
    t0 = $time;
    @(posedge hs_gate);
    chk(32'(($time - t0) / 50), `BMFS_PWM_CYC);
    droop <= 1'h1;
    look(7'h04, 7'h04);
    droop <= 1'h0;
    look(7'h04, 7'h00);
    near_dropout <= 1'h1;
    look(7'h60, 7'h40);
    near_dropout <= 1'h0;
    $display("test start done");
    current_discontinuous <= 1'h1;
    look(7'h02, 7'h02);
    low_input_lockout <= 1'h1;
    look(7'h04, 7'h00);
    current_discontinuous <= 1'h0;
    look(7'h74, 7'h14);
    low_input_lockout <= 1'h0;
    ramp;
    overtemp_threshold <= 1'h1;
    look(7'h74, 7'h14);
    overtemp_threshold <= 1'h0;
    ramp;
    supply_present <= 1'h0;
    look(7'h04, 7'h00);
    supply_present <= 1'h1;
    $display("test faults done");
    xfer(`BMFS_ADR_IRQ_STAT, 32'h0, 1'h0);
    xfer(`BMFS_ADR_IRQ_MASK, 32'h1, 1'h1);
    overload <= 1'h1;
    wdis(1'h1);
    wdis(1'h0);
    chk({31'h0, n >= `BMFS_RETRY_CYC - 2 && n <= `BMFS_RETRY_CYC + 2},
      32'h1);
    wdis(1'h1);
    look(7'h61, 7'h01);
    xfer(`BMFS_ADR_IRQ_MASK, 32'h0, 1'h1);
    look(7'h01, 7'h00);
    xfer(`BMFS_ADR_IRQ_MASK, 32'h1, 1'h1);
    overload <= 1'h0;
    xfer(`BMFS_ADR_IRQ_STAT, 32'h0, 1'h0);
    chk(q & 32'h3, 32'h3);
    look(7'h01, 7'h00);
    ramp;
    xfer(`BMFS_ADR_LIM_CNT, 32'h0, 1'h0);
    chk(q, 32'h0);
    $display("test overload done");
    report_and_stop;
  end
endmodule
